/* File: src/program_space_address_mapper.sv */
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module program_space_address_mapper (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   // Fetch control
   input wire logic fetch_i,
   input wire logic branch_i,
   input wire logic [23:0] branch_addr_i,
   // Table and data requests
   input wire pspace_pkg::tbl_req_t tbl_i,
   input wire pspace_pkg::data_req_t data_i,
   input wire pspace_pkg::mac_req_t mac_i,
   // Program memory
   input wire logic [23:0] pmem_rdata_i,
   output logic [23:0] pmem_addr_o,
   output logic pmem_rd_o,
   output logic pmem_wr_o,
   output logic pmem_wr_high_o,
   output logic [15:0] pmem_wdata_o,
   // Data memory
   output logic [15:0] xmem_addr_o,
   output logic xmem_en_o,
   output logic [15:0] ymem_addr_o,
   output logic ymem_en_o,
   output logic mac_x_err_o,
   // Results to the core
   output logic [15:0] rd_data_o,
   output logic rd_valid_o,
   output logic [1:0] stall_o
);
   import pspace_pkg::*;

   logic rst_s1_r;
   logic rst_s2_r;
   logic rst_n;
   logic [7:0] table_page_r;
   logic [7:0] visibility_page_r;
   logic [15:0] core_control_reg_r;
   logic visibility_enable;
   logic [23:0] pc_r;
   psrc_t src_nxt;
   psrc_t src_r;
   logic [23:0] paddr_nxt;
   logic win_hit;
   logic [1:0] stall_nxt;
   logic tbl_high_r;
   logic tbl_byte_r;
   logic tbl_bsel_r;
   logic rd_pend_r;

   // Y block test shared by decode and the check below
   function automatic logic in_y(input logic [15:0] a);
      in_y = (a >= Y_BASE) && (a <= Y_TOP);
   endfunction

   // Reset release through two flops so deassertion is clean
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign rst_n = rst_s2_r;

   // Page and control registers
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         table_page_r <= TABLE_PAGE_RST;
         visibility_page_r <= VIS_PAGE_RST;
         core_control_reg_r <= CORE_CTRL_RST;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            REG_TABLE_PAGE: table_page_r <= reg_wdata_i[PAGE_W-1:0];
            REG_VIS_PAGE: visibility_page_r <= reg_wdata_i[PAGE_W-1:0];
            REG_CORE_CTRL: core_control_reg_r <= reg_wdata_i;
            default: ;
         endcase
      end
   end
   assign visibility_enable = core_control_reg_r[VIS_EN_BIT];

   // Page writes land on the next edge; upper write data bits are dropped
   a_table_page_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (reg_wr_i && reg_addr_i == REG_TABLE_PAGE) |=> table_page_r == $past(reg_wdata_i[PAGE_W-1:0]))
      else $error("table page write lost");
   a_vis_page_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (reg_wr_i && reg_addr_i == REG_VIS_PAGE) |=> visibility_page_r == $past(reg_wdata_i[PAGE_W-1:0]))
      else $error("visibility page write lost");

   // Read data one cycle after the strobe; unmapped reads as zero
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o <= 16'h0000;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            REG_TABLE_PAGE: reg_rdata_o <= {8'h00, table_page_r};
            REG_VIS_PAGE: reg_rdata_o <= {8'h00, visibility_page_r};
            REG_CORE_CTRL: reg_rdata_o <= core_control_reg_r;
            REG_STATUS: reg_rdata_o <= {8'h00, src_r, 2'b00, stall_o};
            default: reg_rdata_o <= 16'h0000;
         endcase
      end else begin
         reg_rdata_o <= 16'h0000;
      end
   end

   // Fetch counter; steps by two so words line up with data addressing
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         pc_r <= PC_RESET;
      end else if (branch_i) begin
         pc_r <= {1'b0, branch_addr_i[22:1], 1'b0};
      end else if (fetch_i && src_nxt == SRC_FETCH) begin
         pc_r <= {1'b0, pc_r[22:0] + PC_STEP[22:0]};
      end
   end

   // Branch target is forced even and kept below the configuration half
   a_branch_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      branch_i |=> pc_r == {1'b0, $past(branch_addr_i[22:1]), 1'b0})
      else $error("branch target not loaded");
   a_pc_user_half: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      !pc_r[CFG_BIT])
      else $error("fetch counter left user space");

   // Window hit is blocked while a table op runs
   assign win_hit = data_i.req && data_i.ea[DADDR_W-1] && visibility_enable && !tbl_i.req;

   // A window access needs the enable bit and the top EA bit when it was taken
   a_win_enable: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (src_r == SRC_WIN) |-> $past(visibility_enable) && $past(data_i.ea[DADDR_W-1]))
      else $error("window taken without enable");

   // Program address source select; table beats window beats fetch
   always_comb begin
      src_nxt = SRC_NONE;
      paddr_nxt = 24'h000000;
      if (tbl_i.req) begin
         src_nxt = SRC_TABLE;
         paddr_nxt = {table_page_r, tbl_i.ea};
      end else if (win_hit) begin
         src_nxt = SRC_WIN;
         paddr_nxt = {1'b0, visibility_page_r, data_i.ea[WIN_LOW_W-1:0]};
      end else if (fetch_i) begin
         src_nxt = SRC_FETCH;
         paddr_nxt = {1'b0, pc_r[22:1], 1'b0};
      end
   end

   // Table and fetch address forms as seen on the memory side
   a_table_addr_map: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      tbl_i.req |=> pmem_addr_o == {$past(table_page_r), $past(tbl_i.ea)})
      else $error("table address wrong");
   a_fetch_addr: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (fetch_i && !tbl_i.req && !win_hit) |=> pmem_addr_o == {1'b0, $past(pc_r[22:1]), 1'b0})
      else $error("fetch address wrong");
   a_fetch_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (src_r == SRC_FETCH) |-> pmem_rd_o && !pmem_wr_o)
      else $error("fetch not a read");

   // Extra cycles taken by a windowed access
   always_comb begin
      stall_nxt = 2'h0;
      if (win_hit) begin
         if (data_i.in_repeat) begin
            stall_nxt = data_i.rep_edge ? STALL_TWO : 2'h0;
         end else begin
            case (data_i.iclass)
               IC_MAC: stall_nxt = STALL_ONE;
               IC_MOVE: stall_nxt = STALL_ONE;
               IC_OTHER: stall_nxt = STALL_TWO;
               default: stall_nxt = STALL_TWO;
            endcase
         end
      end
   end

   // Stall only ever follows a window hit
   a_repeat_edge: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (win_hit && data_i.in_repeat && data_i.rep_edge) |=> stall_o == STALL_TWO)
      else $error("repeat edge iteration not two");
   a_no_win_stall: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      !win_hit |=> stall_o == 2'h0)
      else $error("stall without window");

   // Program memory request
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         pmem_addr_o <= 24'h000000;
         pmem_rd_o <= 1'b0;
         pmem_wr_o <= 1'b0;
         pmem_wr_high_o <= 1'b0;
         pmem_wdata_o <= 16'h0000;
         src_r <= SRC_NONE;
         stall_o <= 2'h0;
      end else begin
         pmem_addr_o <= paddr_nxt;
         src_r <= src_nxt;
         stall_o <= stall_nxt;
         pmem_rd_o <= (src_nxt == SRC_FETCH) || (src_nxt == SRC_WIN && !data_i.wr)
                      || (src_nxt == SRC_TABLE && !tbl_i.wr);
         pmem_wr_o <= (src_nxt == SRC_TABLE) && tbl_i.wr;
         pmem_wr_high_o <= tbl_i.high;
         pmem_wdata_o <= tbl_i.high ? {8'h00, reg_wdata_i[7:0]} : reg_wdata_i;
      end
   end

   // Only table ops write, and a write never reads in the same cycle
   a_table_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (tbl_i.req && tbl_i.wr) |=> pmem_wr_o && !pmem_rd_o && pmem_wr_high_o == $past(tbl_i.high))
      else $error("table write strobe wrong");
   a_write_source: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      pmem_wr_o |-> src_r == SRC_TABLE)
      else $error("write from non-table source");

   // Read context captured for the returning word
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         tbl_high_r <= 1'b0;
         tbl_byte_r <= 1'b0;
         tbl_bsel_r <= 1'b0;
         rd_pend_r <= 1'b0;
      end else begin
         tbl_high_r <= tbl_i.req && tbl_i.high;
         tbl_byte_r <= tbl_i.req && tbl_i.byte_mode;
         tbl_bsel_r <= tbl_i.ea[0];
         rd_pend_r <= (src_nxt == SRC_TABLE && !tbl_i.wr) || (src_nxt == SRC_WIN && !data_i.wr);
      end
   end

   // Returned data, lane steering for table and window reads
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_o <= 16'h0000;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= rd_pend_r;
         if (!rd_pend_r) begin
            rd_data_o <= 16'h0000;
         end else if (src_r == SRC_WIN) begin
            rd_data_o <= pmem_rdata_i[15:0];
         end else if (tbl_high_r) begin
            if (tbl_byte_r && tbl_bsel_r) begin
               rd_data_o <= 16'h0000;
            end else begin
               rd_data_o <= {8'h00, pmem_rdata_i[23:16]};
            end
         end else if (tbl_byte_r) begin
            rd_data_o <= {8'h00, tbl_bsel_r ? pmem_rdata_i[15:8] : pmem_rdata_i[7:0]};
         end else begin
            rd_data_o <= pmem_rdata_i[15:0];
         end
      end
   end

   // Lane checks use the address bit on the bus, not the captured select
   a_win_read_data: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (src_r == SRC_WIN && pmem_rd_o) |=> rd_valid_o && rd_data_o == $past(pmem_rdata_i[15:0]))
      else $error("window read data wrong");
   a_low_word_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (src_r == SRC_TABLE && pmem_rd_o && !tbl_high_r && !tbl_byte_r)
      |=> rd_data_o == $past(pmem_rdata_i[15:0]))
      else $error("low word read wrong");
   a_low_byte_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (src_r == SRC_TABLE && pmem_rd_o && !tbl_high_r && tbl_byte_r)
      |=> rd_data_o[7:0] == ($past(pmem_addr_o[0]) ? $past(pmem_rdata_i[15:8]) : $past(pmem_rdata_i[7:0])))
      else $error("low byte read wrong");
   a_high_word_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (src_r == SRC_TABLE && pmem_rd_o && tbl_high_r && !tbl_byte_r)
      |=> rd_data_o == {8'h00, $past(pmem_rdata_i[23:16])})
      else $error("high word read wrong");

   // Data space routing; Y sits inside X, split only for MAC reads
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         xmem_addr_o <= 16'h0000;
         xmem_en_o <= 1'b0;
         ymem_addr_o <= 16'h0000;
         ymem_en_o <= 1'b0;
         mac_x_err_o <= 1'b0;
      end else if (mac_i.mac) begin
         xmem_addr_o <= mac_i.xa;
         xmem_en_o <= !in_y(mac_i.xa) && mac_i.xa <= DATA_TOP;
         ymem_addr_o <= mac_i.ya;
         ymem_en_o <= in_y(mac_i.ya);
         mac_x_err_o <= in_y(mac_i.xa);
      end else begin
         xmem_addr_o <= data_i.ea;
         xmem_en_o <= data_i.req && !win_hit && data_i.ea <= DATA_TOP;
         ymem_addr_o <= 16'h0000;
         ymem_en_o <= 1'b0;
         mac_x_err_o <= 1'b0;
      end
   end

   // Dual-operand and composite data routing
   a_mac_x_excl: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (mac_i.mac && in_y(mac_i.xa)) |=> !xmem_en_o && mac_x_err_o)
      else $error("MAC X read reached Y block");
   a_mac_pointers: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      mac_i.mac |=> xmem_addr_o == $past(mac_i.xa) && ymem_addr_o == $past(mac_i.ya))
      else $error("MAC pointer routing wrong");
   a_mac_y_en: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (mac_i.mac && in_y(mac_i.ya)) |=> ymem_en_o)
      else $error("MAC Y read not enabled");
   a_composite_x: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (!mac_i.mac && data_i.req && data_i.ea <= DATA_TOP) |=> xmem_en_o && xmem_addr_o == $past(data_i.ea))
      else $error("composite access not on X");
   a_y_inside_x: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      ymem_en_o |-> ymem_addr_o >= Y_BASE && ymem_addr_o <= Y_TOP && ymem_addr_o <= DATA_TOP)
      else $error("Y access outside its block");

   // Checks
   a_win_addr_map: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (win_hit && !branch_i) |=> (pmem_addr_o == {1'b0, visibility_page_r, $past(data_i.ea[14:0])}))
      else $error("window address wrong");
   a_table_blocks_win: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      tbl_i.req |=> (src_r == SRC_TABLE))
      else $error("window not suspended in table op");
   a_user_bit23: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (src_r != SRC_TABLE) |-> !pmem_addr_o[CFG_BIT])
      else $error("bit 23 set outside table access");
   a_fetch_even: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (src_r == SRC_FETCH) |-> !pmem_addr_o[0])
      else $error("fetch address odd");
   a_pc_step_two: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (fetch_i && src_nxt == SRC_FETCH && !branch_i && pc_r[22:0] != 23'h7ffffe)
      |=> pc_r == $past(pc_r) + 24'h000002)
      else $error("fetch step not two");
   a_stall_other: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (win_hit && !data_i.in_repeat && data_i.iclass == IC_OTHER) |=> stall_o == 2'h2)
      else $error("other class stall not two");
   a_stall_move: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (win_hit && !data_i.in_repeat && data_i.iclass != IC_OTHER) |=> stall_o == 2'h1)
      else $error("move class stall not one");
   a_repeat_mid: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (win_hit && data_i.in_repeat && !data_i.rep_edge) |=> stall_o == 2'h0)
      else $error("repeat middle iteration stalled");
   a_high_byte_one: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (tbl_i.req && !tbl_i.wr && tbl_i.high && tbl_i.byte_mode && tbl_i.ea[0]) |-> ##2 rd_data_o == 16'h0000)
      else $error("high byte select one not zero");
   a_mac_y_only: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      !mac_i.mac |=> !ymem_en_o)
      else $error("Y path used outside MAC");
endmodule
`default_nettype wire

/* File: src/pspace_pkg.sv */
package pspace_pkg;
   // Program address construction
   localparam int PADDR_W = 24;
   localparam int DADDR_W = 16;
   localparam int PAGE_W = 8;
   localparam int CFG_BIT = 23;
   localparam int WIN_LOW_W = 15;
   localparam logic [23:0] USER_TOP = 24'h7ffffe;
   localparam logic [23:0] PC_STEP = 24'h000002;
   localparam logic [23:0] PC_RESET = 24'h000000;
   // Register port offsets
   localparam logic [3:0] REG_TABLE_PAGE = 4'h0;
   localparam logic [3:0] REG_VIS_PAGE = 4'h1;
   localparam logic [3:0] REG_CORE_CTRL = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam int VIS_EN_BIT = 2;
   localparam logic [7:0] TABLE_PAGE_RST = 8'h00;
   localparam logic [7:0] VIS_PAGE_RST = 8'h00;
   localparam logic [15:0] CORE_CTRL_RST = 16'h0000;
   // Data space split, 256 bytes with a Y block inside
   localparam logic [15:0] DATA_TOP = 16'h00ff;
   localparam logic [15:0] Y_BASE = 16'h0080;
   localparam logic [15:0] Y_TOP = 16'h00bf;
   // Extra cycles for windowed accesses
   localparam logic [1:0] STALL_ONE = 2'h1;
   localparam logic [1:0] STALL_TWO = 2'h2;

   typedef enum logic [3:0] {
      SRC_FETCH = 4'b0001,
      SRC_TABLE = 4'b0010,
      SRC_WIN = 4'b0100,
      SRC_NONE = 4'b1000
   } psrc_t;

   typedef enum logic [2:0] {
      IC_MAC = 3'b001,
      IC_MOVE = 3'b010,
      IC_OTHER = 3'b100
   } iclass_t;

   typedef struct packed {
      logic req;
      logic tbl;
      logic high;
      logic byte_mode;
      logic wr;
      logic [15:0] ea;
   } tbl_req_t;

   typedef struct packed {
      logic req;
      logic wr;
      logic [15:0] ea;
      iclass_t iclass;
      logic in_repeat;
      logic rep_edge;
   } data_req_t;

   typedef struct packed {
      logic mac;
      logic [15:0] xa;
      logic [15:0] ya;
   } mac_req_t;
endpackage

/* File: verification/pmem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pmem_model (
   input wire logic [23:0] pmem_addr_i,
   output logic [23:0] pmem_rdata_o
);
   // Contents follow the low 16 address bits, so every word within one table page differs and the bench can predict it
   // One address holds a low word and a high byte side by side
   assign pmem_rdata_o = {pmem_addr_i[7:0] ^ 8'hc3, pmem_addr_i[15:0] ^ 16'h6b2d};
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module tb_top;
   import pspace_pkg::*;
   logic clk_sys_i, rst_b_i, reg_wr_i, reg_rd_i, fetch_i, branch_i;
   logic [3:0] reg_addr_i;
   logic [15:0] reg_wdata_i, reg_rdata_o, pmem_wdata_o, xmem_addr_o, ymem_addr_o, rd_data_o, ea, e16, msk;
   logic [23:0] branch_addr_i, pmem_rdata_i, pmem_addr_o, pa, pw;
   logic [23:0] fa [3];
   tbl_req_t tbl_i;
   data_req_t data_i;
   mac_req_t mac_i;
   logic pmem_rd_o, pmem_wr_o, pmem_wr_high_o, xmem_en_o, ymem_en_o, mac_x_err_o, rd_valid_o;
   logic [1:0] stall_o;
   int error_cnt, comparisons;
   iclass_t ic [5] = '{IC_MAC, IC_MOVE, IC_OTHER, IC_MAC, IC_OTHER};
   logic [1:0] es [5] = '{STALL_ONE, STALL_ONE, STALL_TWO, STALL_TWO, 2'h0};

   program_space_address_mapper u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .fetch_i(fetch_i), .branch_i(branch_i), .branch_addr_i(branch_addr_i), .tbl_i(tbl_i), .data_i(data_i),
      .mac_i(mac_i), .pmem_rdata_i(pmem_rdata_i), .pmem_addr_o(pmem_addr_o), .pmem_rd_o(pmem_rd_o),
      .pmem_wr_o(pmem_wr_o), .pmem_wr_high_o(pmem_wr_high_o), .pmem_wdata_o(pmem_wdata_o),
      .xmem_addr_o(xmem_addr_o), .xmem_en_o(xmem_en_o), .ymem_addr_o(ymem_addr_o), .ymem_en_o(ymem_en_o),
      .mac_x_err_o(mac_x_err_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .stall_o(stall_o));
   pmem_model u_pmem (.pmem_addr_i(pmem_addr_o), .pmem_rdata_o(pmem_rdata_i));

   // Same content rule as the memory model, kept apart from the design
   function automatic logic [23:0] pword(input logic [23:0] a);
      return {a[7:0] ^ 8'hc3, a[15:0] ^ 16'h6b2d};
   endfunction

   task automatic finish_test();
      $display("TB: errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1;
      `CHK(reg_rdata_o, exp)
   endtask

   // One-cycle request; returns when the memory side outputs have settled
   task automatic issue(input tbl_req_t t, input data_req_t d, input mac_req_t m);
      @(posedge clk_sys_i);
      tbl_i <= t;
      data_i <= d;
      mac_i <= m;
      @(posedge clk_sys_i);
      tbl_i <= '0;
      data_i <= '0;
      mac_i <= '0;
      #1;
   endtask

   task automatic step();
      @(posedge clk_sys_i);
      #1;
   endtask

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // Guard against a hang anywhere in the sequence
   initial begin
      #100000;
      error_cnt++;
      finish_test();
   end

   initial begin
      rst_b_i = 1'b0;
      {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, fetch_i, branch_i, branch_addr_i} = '0;
      tbl_i = '0;
      data_i = '0;
      mac_i = '0;
      repeat (2) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      // Register reset values, read-back and an unmapped slot
      reg_rd(REG_TABLE_PAGE, 16'h0000);
      reg_rd(REG_VIS_PAGE, 16'h0000);
      reg_rd(REG_CORE_CTRL, 16'h0000);
      reg_rd(REG_STATUS, 16'h0080);
      reg_wr(4'hf, 16'hffff);
      reg_rd(4'hf, 16'h0000);
      reg_wr(REG_TABLE_PAGE, 16'h0080);
      reg_rd(REG_TABLE_PAGE, 16'h0080);
      // Table reads into configuration space: word and both byte selects, low and high
      for (int k = 0; k < 6; k++) begin
         ea = 16'h4a10 | 16'(k % 3 == 2);
         pa = {8'h80, ea};
         pw = pword(pa);
         issue('{1'b1, 1'b1, k > 2, k % 3 != 0, 1'b0, ea}, '0, '0);
         `CHK(pmem_addr_o, pa)
         `CHK(pmem_rd_o, 1'b1)
         step();
         case (k)
            0: e16 = pw[15:0];
            1: e16 = {8'h00, pw[7:0]};
            2: e16 = {8'h00, pw[15:8]};
            3: e16 = {8'h00, pw[23:16]};
            4: e16 = {8'h00, pw[23:16]};
            default: e16 = 16'h0000;
         endcase
         msk = (k % 3 == 0) ? 16'hffff : 16'h00ff;
         `CHK(rd_valid_o, 1'b1)
         `CHK(rd_data_o & msk, e16)
      end
      // Table writes to both halves; write data comes from the register port
      reg_wr(REG_VIS_PAGE, 16'h125a);
      for (int h = 0; h < 2; h++) begin
         issue('{1'b1, 1'b1, h[0], 1'b0, 1'b1, 16'h0246}, '0, '0);
         `CHK({pmem_wr_o, pmem_wr_high_o}, {1'b1, h[0]})
         `CHK(pmem_addr_o, 24'h800246)
         `CHK(pmem_wdata_o, h[0] ? 16'h005a : 16'h125a)
      end
      // Windowed reads with every stall case
      reg_wr(REG_CORE_CTRL, 16'h0004);
      for (int k = 0; k < 5; k++) begin
         ea = 16'h8120 | 16'(2 * k);
         pa = {1'b0, 8'h5a, ea[14:0]};
         pw = pword(pa);
         issue('0, '{1'b1, 1'b0, ea, ic[k], k > 2, k == 3}, '0);
         `CHK(pmem_addr_o, pa)
         `CHK(stall_o, es[k])
         step();
         `CHK(rd_data_o, pw[15:0])
      end
      // Table and window in the same cycle: the table wins
      issue('{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0300}, '{1'b1, 1'b0, 16'h8300, IC_MOVE, 1'b0, 1'b0}, '0);
      `CHK(pmem_addr_o, 24'h800300)
      issue('0, '{1'b1, 1'b0, 16'h0123, IC_MOVE, 1'b0, 1'b0}, '0);
      `CHK({pmem_rd_o, stall_o}, 3'h0)
      reg_wr(REG_CORE_CTRL, 16'h0000);
      issue('0, '{1'b1, 1'b0, 16'h8123, IC_MOVE, 1'b0, 1'b0}, '0);
      `CHK({pmem_rd_o, stall_o}, 3'h0)
      // Fetch across the top of user space
      @(posedge clk_sys_i);
      branch_addr_i <= 24'hffffff;
      branch_i <= 1'b1;
      @(posedge clk_sys_i);
      branch_i <= 1'b0;
      fetch_i <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         step();
         fa[k] = pmem_addr_o;
         `CHK({pmem_rd_o, pmem_addr_o[23], pmem_addr_o[0]}, 3'h4)
      end
      fetch_i <= 1'b0;
      `CHK((fa[1] - fa[0]) & 24'h7fffff, PC_STEP)
      `CHK((fa[2] - fa[1]) & 24'h7fffff, PC_STEP)
      // Dual-operand routing and the composite path
      issue('0, '0, '{1'b1, 16'h0010, 16'h0090});
      `CHK({xmem_en_o, ymem_en_o, mac_x_err_o, xmem_addr_o, ymem_addr_o}, {3'h6, 32'h00100090})
      issue('0, '0, '{1'b1, 16'h0088, 16'h00a0});
      `CHK({xmem_en_o, mac_x_err_o}, 2'h1)
      issue('0, '{1'b1, 1'b0, 16'h0088, IC_MOVE, 1'b0, 1'b0}, '0);
      `CHK({xmem_en_o, ymem_en_o, xmem_addr_o}, {2'h2, 16'h0088})
      finish_test();
   end
endmodule
`default_nettype wire
